// ===== shared/tbps_pkg.sv
// constants shared by the tx buffer parser and its testbench
package tbps_pkg;

    // ************************************************
    // register byte offsets on the avalon slave
    // ************************************************
    localparam logic [3:0] ADDR_DATA   = 4'h0;  // write: next buffer dword
    localparam logic [3:0] ADDR_STATUS = 4'h4;  // read: pop status word
    localparam logic [3:0] ADDR_CONFIG = 4'h8;  // read/write: control bits
    localparam logic [3:0] ADDR_INFO   = 4'hc;  // read: count/error, w1c error

    // ************************************************
    // register fields and reset values
    // ************************************************
    localparam int         CFG_DISCARD = 0;      // status_discard_overrun_enable
    localparam int         CFG_DEFCHK  = 1;      // deferral checking enable
    localparam logic [1:0] CFG_RST     = 2'h0;
    localparam int         INFO_ERR    = 16;     // transmit_error_flag position
    localparam int         INFO_ERR_BE = 2;      // byte lane holding the flag

    // ************************************************
    // first command word fields
    // ************************************************
    localparam int A_ALIGN_LO = 24;
    localparam int A_OFF_LO   = 16;
    localparam int A_FS       = 13;
    localparam int A_LS       = 12;
    localparam int SIZE_HI    = 10;

    // ************************************************
    // second command word fields
    // ************************************************
    localparam int B_TAG_LO = 16;
    localparam int B_NOCRC  = 13;
    localparam int B_NOPAD  = 12;

    // ************************************************
    // status word fields
    // ************************************************
    localparam int ST_ES    = 15;
    localparam int ST_LCAR  = 11;
    localparam int ST_NCAR  = 10;
    localparam int ST_LATE  = 9;
    localparam int ST_EXCOL = 8;
    localparam int ST_COLLO = 3;
    localparam int ST_EXDEF = 2;
    localparam int ST_DEFER = 0;

    // end alignment codes, byte count minus one
    localparam logic [11:0] ALIGN4_M  = 12'h003;
    localparam logic [11:0] ALIGN16_M = 12'h00f;
    localparam logic [11:0] ALIGN32_M = 12'h01f;

endpackage

// ===== shared/tbps_sts_if.sv
// status fifo link between the parser and its fifo
`timescale 1ns/1ns
interface tbps_sts_if #(parameter int CW = 5);
    logic          push;
    logic [31:0]   wdata;
    logic          pop;
    logic [31:0]   head;
    logic          full;
    logic          empty;
    logic [CW-1:0] count;
    modport fifo (input push, wdata, pop, output head, full, empty, count);
    modport user (output push, wdata, pop, input head, full, empty, count);
endinterface

// ===== src/tbps_sts_fifo.sv
// tx status word fifo
`timescale 1ns/1ns
module tbps_sts_fifo #(
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // fifo side of the link
    tbps_sts_if.fifo port
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [31:0]   mem [DEPTH];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [CW-1:0] cnt_q;
    logic          do_push;
    logic          do_pop;

    // a push into a full fifo or a pop from an empty one is ignored
    assign do_push    = port.push && (cnt_q != CW'(DEPTH));
    assign do_pop     = port.pop && (cnt_q != '0);
    assign port.head  = mem[rp_q];
    assign port.full  = (cnt_q == CW'(DEPTH));
    assign port.empty = (cnt_q == '0);
    assign port.count = cnt_q;

    // storage, no reset needed on the data array
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wp_q] <= port.wdata;
        end
    end

    // pointers wrap explicitly so depth need not be a power of two
    always_ff @(posedge clk) begin
        if (reset) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) begin
                wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + PW'(1);
            end
            if (do_pop) begin
                rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + PW'(1);
            end
            cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
        end
    end
endmodule

// ===== src/tbps_tx_parser.sv
// tx buffer parser: command words, byte stripping, mac feed and status words
`timescale 1ns/1ns
module tbps_tx_parser #(
    parameter int STS_DEPTH = 16
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // byte stream to the mac_interface_layer
    output logic             mac_valid,
    output logic      [7:0]  mac_data,
    output logic             mac_last,
    output logic             mac_no_crc,
    output logic             mac_no_pad,
    input  wire logic        mac_ready,
    // per packet result from the mac
    input  wire logic        mac_done,
    input  wire logic        mac_carrier_lost,
    input  wire logic        mac_no_carrier,
    input  wire logic        mac_late_col,
    input  wire logic        mac_excess_col,
    input  wire logic [3:0]  mac_col_count,
    input  wire logic        mac_excess_defer,
    input  wire logic        mac_deferred
);
    import tbps_pkg::*;

    localparam int CW = $clog2(STS_DEPTH + 1);

    typedef enum logic [2:0] {S_CMDA, S_CMDB, S_DATA, S_EMIT, S_WAIT, S_PUSH} tbps_state_e;

    // ************************************************
    // helpers
    // ************************************************
    // reserved alignment code falls back to 4-byte, the safest reading
    function automatic logic [11:0] align_mask(input logic [1:0] code);
        case (code)
            2'b01:   align_mask = ALIGN16_M;
            2'b10:   align_mask = ALIGN32_M;
            default: align_mask = ALIGN4_M;
        endcase
    endfunction

    function automatic logic [3:0] lane_mask(input logic [11:0] pos, input logic [11:0] lo,
                                             input logic [11:0] hi);
        logic [3:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b] = ((pos + 12'(b)) >= lo) && ((pos + 12'(b)) < hi);
        end
        return m;
    endfunction

    function automatic logic [1:0] low_lane(input logic [3:0] m);
        if (m[0]) begin
            return 2'd0;
        end else if (m[1]) begin
            return 2'd1;
        end else if (m[2]) begin
            return 2'd2;
        end
        return 2'd3;
    endfunction

    // ************************************************
    // state
    // ************************************************
    tbps_state_e state_q;
    logic [1:0]  align_q;
    logic [4:0]  off_q;
    logic        fs_q;
    logic        ls_q;
    logic [10:0] bsize_q;
    logic [31:0] b_q;
    logic [9:0]  wi_q;
    logic [9:0]  tw_q;
    logic [31:0] word_q;
    logic [3:0]  mask_q;
    logic        lastw_q;
    logic [11:0] cnt_q;
    logic [11:0] sum_q;
    logic        err_q;
    logic        ovr_q;
    logic [31:0] st_q;
    logic [1:0]  cfg_q;
    logic        wait_q;
    logic [31:0] rdata_q;
    logic        popok_q;
    logic        mac_valid_q;
    logic [7:0]  mac_data_q;
    logic        mac_last_q;
    logic        mac_no_crc_q;
    logic        mac_no_pad_q;
    logic        done_q;

    logic        fire;
    logic        data_fire;
    logic        word_ok;
    logic [31:0] rd_val;
    logic [3:0]  lmask;
    logic        emit_adv;
    logic        finishing;
    logic        chk;
    logic        len_bad;
    logic        b_mis;
    logic        drop;
    logic [CW-1:0] used;
    logic [31:0] st_d;
    logic [11:0] end_a;

    tbps_sts_if #(.CW(CW)) sts ();

    tbps_sts_fifo #(.DEPTH(STS_DEPTH)) u_fifo (
        .clk   (core_clk),
        .reset (reset),
        .port  (sts.fifo)
    );

    // ************************************************
    // avalon slave
    // ************************************************
    // waitrequest drops for exactly the completing cycle; a data write waits
    // while the parser is still feeding bytes, which is the host back-pressure
    assign word_ok   = (state_q == S_CMDA) || (state_q == S_CMDB) || (state_q == S_DATA);
    assign fire      = (avs_read || avs_write) && !wait_q;
    assign data_fire = fire && avs_write && (avs_address == ADDR_DATA);
    assign used      = ovr_q ? '0 : sts.count;

    always_comb begin
        rd_val = '0;
        if (avs_address == ADDR_STATUS) begin
            rd_val = sts.empty ? '0 : sts.head;
        end else if (avs_address == ADDR_CONFIG) begin
            rd_val = {30'h0, cfg_q};
        end else if (avs_address == ADDR_INFO) begin
            rd_val = {15'h0, err_q, 16'(used)};
        end
    end

    // read data is frozen at the decision so it stands at the completing edge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wait_q  <= 1'b1;
            rdata_q <= '0;
            popok_q <= 1'b0;
        end else if (wait_q && (avs_read || avs_write) &&
                     !(avs_write && (avs_address == ADDR_DATA) && !word_ok)) begin
            wait_q  <= 1'b0;
            rdata_q <= avs_read ? rd_val : '0;
            popok_q <= avs_read && (avs_address == ADDR_STATUS) && !sts.empty;
        end else begin
            wait_q  <= 1'b1;
        end
    end

    // control bits
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cfg_q <= CFG_RST;
        end else if (fire && avs_write && (avs_address == ADDR_CONFIG) && avs_byteenable[0]) begin
            cfg_q <= avs_writedata[1:0];
        end
    end

    // ************************************************
    // command parsing and byte feed
    // ************************************************
    // whole-dword lead-in falls outside the byte window
    assign lmask = lane_mask({wi_q, 2'b00}, {7'h0, off_q}, {7'h0, off_q} + {1'b0, bsize_q});
    assign end_a = {7'h0, avs_writedata[A_OFF_LO +: 5]} + {1'b0, avs_writedata[SIZE_HI:0]};
    assign emit_adv = !mac_valid_q || mac_ready;

    assign finishing = (state_q == S_CMDB && data_fire && tw_q == '0) ||
                       (state_q == S_DATA && data_fire && lmask == '0 && (wi_q + 10'd1 == tw_q)) ||
                       (state_q == S_EMIT && emit_adv && mask_q == '0 && lastw_q);
    assign chk       = finishing && ls_q;
    assign len_bad   = (cnt_q != {1'b0, b_q[SIZE_HI:0]}) || (sum_q != {1'b0, b_q[SIZE_HI:0]});
    assign b_mis     = state_q == S_CMDB && data_fire && !fs_q && (avs_writedata != b_q);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= S_CMDA;
            align_q <= '0;
            off_q   <= '0;
            fs_q    <= 1'b0;
            ls_q    <= 1'b0;
            bsize_q <= '0;
            b_q     <= '0;
            wi_q    <= '0;
            tw_q    <= '0;
            word_q  <= '0;
            mask_q  <= '0;
            lastw_q <= 1'b0;
            sum_q   <= '0;
        end else begin
            case (state_q)
                S_CMDA: begin
                    if (data_fire) begin
                        align_q <= avs_writedata[A_ALIGN_LO +: 2];
                        off_q   <= avs_writedata[A_OFF_LO +: 5];
                        fs_q    <= avs_writedata[A_FS];
                        ls_q    <= avs_writedata[A_LS];
                        bsize_q <= avs_writedata[SIZE_HI:0];
                        tw_q    <= 10'(((end_a + align_mask(avs_writedata[A_ALIGN_LO +: 2])) &
                                        ~align_mask(avs_writedata[A_ALIGN_LO +: 2])) >> 2);
                        sum_q   <= (avs_writedata[A_FS] ? 12'h0 : sum_q) + {1'b0, avs_writedata[SIZE_HI:0]};
                        state_q <= S_CMDB;
                    end
                end
                S_CMDB: begin
                    if (data_fire) begin
                        // the first buffer's copy is the reference for later ones
                        if (fs_q) begin
                            b_q <= avs_writedata;
                        end
                        wi_q <= '0;
                        state_q <= (tw_q == '0) ? (ls_q ? S_WAIT : S_CMDA) : S_DATA;
                    end
                end
                S_DATA: begin
                    if (data_fire) begin
                        wi_q    <= wi_q + 10'd1;
                        word_q  <= avs_writedata;
                        mask_q  <= lmask;
                        lastw_q <= (wi_q + 10'd1 == tw_q);
                        if (lmask != '0) begin
                            state_q <= S_EMIT;
                        end else if (wi_q + 10'd1 == tw_q) begin
                            state_q <= ls_q ? S_WAIT : S_CMDA;
                        end
                    end
                end
                S_EMIT: begin
                    if (emit_adv && mask_q != '0) begin
                        mask_q <= mask_q & (mask_q - 4'd1);
                    end else if (emit_adv) begin
                        state_q <= !lastw_q ? S_DATA : (ls_q ? S_WAIT : S_CMDA);
                    end
                end
                S_WAIT: begin
                    if (mac_done || done_q) begin
                        state_q <= S_PUSH;
                    end
                end
                S_PUSH: begin
                    // hold here while the fifo is full and discard mode is off; with discard on, leave without pushing
                    if (!sts.full || cfg_q[CFG_DISCARD]) begin
                        state_q <= S_CMDA;
                    end
                end
                default: state_q <= S_CMDA;
            endcase
        end
    end

    // byte output register; unused lanes are simply never loaded
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mac_valid_q  <= 1'b0;
            mac_data_q   <= '0;
            mac_last_q   <= 1'b0;
            mac_no_crc_q <= 1'b0;
            mac_no_pad_q <= 1'b0;
            cnt_q        <= '0;
        end else begin
            if (state_q == S_CMDA && data_fire && avs_writedata[A_FS]) begin
                cnt_q <= '0;
            end
            if (state_q == S_EMIT && emit_adv && mask_q != '0) begin
                // lowest set lane, byte lane 0 is D[7:0]
                mac_valid_q  <= 1'b1;
                mac_data_q   <= word_q[8 * low_lane(mask_q) +: 8];
                // last flag on the final payload byte
                mac_last_q   <= ((mask_q & (mask_q - 4'd1)) == '0) && ls_q &&
                                ({wi_q, 2'b00} >= ({7'h0, off_q} + {1'b0, bsize_q}));
                mac_no_crc_q <= b_q[B_NOCRC] && !b_q[B_NOPAD];
                mac_no_pad_q <= b_q[B_NOPAD];
                cnt_q        <= cnt_q + 12'd1;
            end else if (mac_ready) begin
                mac_valid_q  <= 1'b0;
                mac_last_q   <= 1'b0;
            end
        end
    end

    // ************************************************
    // status word
    // ************************************************
    always_comb begin
        st_d = '0;
        st_d[31:B_TAG_LO]           = b_q[31:B_TAG_LO];
        st_d[ST_LCAR]               = mac_carrier_lost;
        st_d[ST_NCAR]               = mac_no_carrier;
        st_d[ST_LATE]               = mac_late_col;
        st_d[ST_EXCOL]              = mac_excess_col;
        st_d[ST_COLLO +: 4]         = mac_col_count;
        st_d[ST_EXDEF]              = mac_excess_defer && cfg_q[CFG_DEFCHK];
        st_d[ST_DEFER]              = mac_deferred;
        st_d[ST_ES]                 = |{st_d[11:8], st_d[2:1]};
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= '0;
        end else if (mac_done) begin
            st_q <= st_d;
        end
    end

    // the result can return while padding dwords are still being parsed, so keep it
    always_ff @(posedge core_clk) begin
        if (reset) begin
            done_q <= 1'b0;
        end else if (state_q == S_WAIT) begin
            done_q <= 1'b0;
        end else if (mac_done) begin
            done_q <= 1'b1;
        end
    end

    assign drop      = state_q == S_PUSH && sts.full && cfg_q[CFG_DISCARD];
    assign sts.push  = state_q == S_PUSH && !sts.full && !ovr_q;
    assign sts.wdata = st_q;
    assign sts.pop   = fire && avs_read && (avs_address == ADDR_STATUS) && popok_q;

    // overrun holds pushes off until a status read pops a word; set wins over clear
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ovr_q <= 1'b0;
        end else if (drop) begin
            ovr_q <= 1'b1;
        end else if (sts.pop) begin
            ovr_q <= 1'b0;
        end
    end

    // overrun in discard mode never feeds the error flag
    always_ff @(posedge core_clk) begin
        if (reset) begin
            err_q <= 1'b0;
        end else if ((chk && len_bad) || b_mis) begin
            err_q <= 1'b1;
        end else if (fire && avs_write && avs_address == ADDR_INFO &&
                     avs_byteenable[INFO_ERR_BE] && avs_writedata[INFO_ERR]) begin
            err_q <= 1'b0;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign mac_valid       = mac_valid_q;
    assign mac_data        = mac_data_q;
    assign mac_last        = mac_last_q;
    assign mac_no_crc      = mac_no_crc_q;
    assign mac_no_pad      = mac_no_pad_q;

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_full_stall;
        state_q == S_PUSH && sts.full && !cfg_q[CFG_DISCARD];
    endsequence

    sequence s_overrun;
        state_q == S_PUSH && sts.full && cfg_q[CFG_DISCARD];
    endsequence

    a_tag_copy: assert property (sts.push |-> sts.wdata[31:16] == b_q[31:16])
        else $error("status tag differs from packet tag");
    a_crc_forced: assert property (mac_valid_q && mac_no_pad_q |-> !mac_no_crc_q)
        else $error("crc dropped while padding disabled");
    a_len_error: assert property (chk && len_bad |=> err_q)
        else $error("length mismatch did not raise error");
    a_stall_full: assert property (s_full_stall |-> !sts.push ##1 state_q == S_PUSH)
        else $error("left status stall while fifo full");
    a_overrun_zero: assert property (s_overrun |=> ovr_q ##0 used == '0)
        else $error("overrun did not zero used count");
    a_overrun_noerr: assert property ((s_overrun and !err_q) |=> !err_q)
        else $error("overrun raised error in discard mode");
    a_es_summary: assert property (sts.push |-> sts.wdata[15] == |{sts.wdata[11:8], sts.wdata[2:1]})
        else $error("error summary bit wrong");
    a_exdef_gate: assert property (sts.push && !cfg_q[CFG_DEFCHK] |-> !sts.wdata[2])
        else $error("excess deferral set without checking");
endmodule

// ===== tb/tb_tx_buffer_parser_status.sv
// testbench for the tx buffer parser and status fifo
`timescale 1ns/1ns
module tb_tx_buffer_parser_status;
    import tbps_pkg::*;
    logic        clk = 0, reset = 1, rd = 0, wr = 0, rdy, done, wt, vld, lst, ncrc, npad, ln, nc, np;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wd = 32'h0, rdat, q;
    logic [7:0]  md;
    logic [9:0]  res = 10'h0;
    logic [7:0]  got[$], exp[$];
    int          failures = 0, n_checks = 0;
    initial forever #20 clk = ~clk;
    tbps_tx_parser DUT (.core_clk(clk), .reset(reset), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_byteenable(4'hf), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt),
        .mac_valid(vld), .mac_data(md), .mac_last(lst), .mac_no_crc(ncrc), .mac_no_pad(npad),
        .mac_ready(rdy), .mac_done(done), .mac_carrier_lost(res[0]), .mac_no_carrier(res[1]),
        .mac_late_col(res[2]), .mac_excess_col(res[3]), .mac_col_count(res[7:4]),
        .mac_excess_defer(res[8]), .mac_deferred(res[9]));
    tbps_mac_model MAC (.core_clk(clk), .reset(reset), .mac_valid(vld), .mac_last(lst),
        .mac_ready(rdy), .mac_done(done));
    // collect every byte the mac takes, with its side flags
    always @(posedge clk) if (vld === 1'b1 && rdy === 1'b1) begin
        got.push_back(md);
        ln <= lst;
        nc <= ncrc;
        np <= npad;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one avalon access; request held until waitrequest is seen low at an edge
    task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= r; wr <= !r; adr <= a; wd <= d;
        do begin @(posedge clk); n++; end while (wt !== 1'b0 && n < 5000);
        q = rdat;
        rd <= 1'b0; wr <= 1'b0;
        if (n >= 5000) failures++;
    endtask
    // one single-buffer packet; bad makes the length field one too large
    task automatic pkt(input logic [1:0] al, input logic [4:0] off, input logic [10:0] sz,
                       input logic [15:0] tg, input logic [1:0] fl, input bit bad, input bit rdst);
        int n, lim;
        logic [31:0] w, b, e, inf;
        lim = (al == 2'h1) ? 16 : (al == 2'h2) ? 32 : 4;
        n = ((off + sz + lim - 1) / lim) * lim / 4;
        b = {tg, 2'h0, fl, 1'b0, sz + 11'(bad)};
        got.delete(); exp.delete();
        res <= 10'($urandom);
        // both segment flags set, host pads to alignment
        bus(0, ADDR_DATA, {6'h0, al, 3'h0, off, 4'h3, 1'b0, sz});
        bus(0, ADDR_DATA, b);
        for (int i = 0; i < n; i++) begin
            w = $urandom;
            for (int j = 0; j < 4; j++) if (4*i+j >= off && 4*i+j < off+sz) exp.push_back(w[8*j+:8]);
            bus(0, ADDR_DATA, w);
        end
        if (!rdst) return;
        n = 0;
        do begin bus(1, ADDR_INFO, 0); n++; end while (q[15:0] === 16'h0 && n < 300);
        inf = q;
        chk(inf[15:0], 16'h1);
        chk(got.size(), exp.size());
        foreach (exp[k]) chk(got[k], exp[k]);
        chk(ln, 1'b1);
        chk(nc, b[13] & ~b[12]);
        chk(np, b[12]);
        chk(inf[INFO_ERR], bad);
        e = {tg, |res[3:0] | res[8], 3'h0, res[0], res[1], res[2], res[3], 1'b0, res[7:4], res[8], 1'b0, res[9]};
        bus(1, ADDR_STATUS, 0);
        chk(q, e);
        if (bad) bus(0, ADDR_INFO, 32'h10000);
    endtask
    initial begin
        int i;
        void'($urandom(32'hb56b6077));
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        bus(0, ADDR_CONFIG, 32'h2);
        bus(1, ADDR_CONFIG, 0);
        chk(q, 32'h2);
        bus(1, 4'h1, 0);
        chk(q, 32'h0);
        // every alignment code, random offsets, lengths and command flags
        for (int k = 0; k < 12; k++) pkt(2'(k), 5'($urandom), 11'(1 + $urandom % 80), 16'($urandom),
                                          2'($urandom), 0, 1);
        pkt(2'h1, 5'h1f, 11'h3, 16'h1234, 2'h0, 1, 1);
        // discard mode: overfill the status fifo without reading it
        bus(0, ADDR_CONFIG, 32'h3);
        repeat (17) pkt(2'h0, 5'h0, 11'h1, 16'h55aa, 2'h0, 0, 0);
        i = 0;
        while (done !== 1'b1 && i < 200) begin @(posedge clk); i++; end
        repeat (3) @(posedge clk);
        bus(1, ADDR_INFO, 0);
        chk(q[16:0], 17'h0);
        // a status read ends the overrun; then stall mode must hold the extra status back
        bus(1, ADDR_STATUS, 0);
        chk(q[31:16], 16'h55aa);
        bus(0, ADDR_CONFIG, 32'h2);
        repeat (2) pkt(2'h0, 5'h0, 11'h1, 16'h55aa, 2'h0, 0, 0);
        repeat (30) @(posedge clk);
        bus(1, ADDR_INFO, 0);
        chk(q[16:0], 17'h10);
        // draining frees room, the stalled status lands, and all seventeen come out
        for (int k = 0; k < 17; k++) bus(1, ADDR_STATUS, 0);
        chk(q[31:16], 16'h55aa);
        bus(1, ADDR_INFO, 0);
        chk(q[16:0], 17'h0);
        conclude();
    end
    // hang guard, well past the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        conclude();
    end
endmodule

// ===== tb/tbps_mac_model.sv
// mac side partner: takes bytes with random stalls, then reports one result
`timescale 1ns/1ns
module tbps_mac_model (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // byte stream
    input  wire logic mac_valid,
    input  wire logic mac_last,
    output logic      mac_ready,
    output logic      mac_done
);
    int cnt;
    // stalls keep the parser holding bytes; the result follows the last byte
    always @(posedge core_clk) begin
        mac_ready <= ($urandom % 4) != 0;
        mac_done  <= 1'b0;
        if (reset) begin
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt      <= 0;
            mac_done <= 1'b1;
        end else if (mac_valid && mac_ready && mac_last) begin
            cnt <= 2 + $urandom % 4;
        end
    end
endmodule
